// ---- hw/fic_pkg.sv ----
// Shared constants and types for the four-level interrupt controller
package fic_pkg;

	// Source count and level encoding
	localparam int NUM_SRC = 15;
	localparam int LVL_W   = 2;

	// Special function register addresses
	localparam logic [7:0] ADDR_ENABLE_FIRST   = 8'h00_A8;
	localparam logic [7:0] ADDR_PRIO_LOW_STD   = 8'h00_B8;
	localparam logic [7:0] ADDR_PRIO_HIGH_STD  = 8'h00_B7;
	localparam logic [7:0] ADDR_ENABLE_SECOND  = 8'h00_E8;
	localparam logic [7:0] ADDR_PRIO_LOW_TMR   = 8'h00_F8;
	localparam logic [7:0] ADDR_PRIO_HIGH_TMR  = 8'h00_F7;
	localparam logic [7:0] ADDR_FLAGS_STD      = 8'h00_C0;
	localparam logic [7:0] ADDR_FLAGS_TMR      = 8'h00_C8;
	localparam logic [7:0] ADDR_FLAGS_OVF      = 8'h00_C9;

	// Bit positions inside the first enable register
	localparam int EN_GLOBAL_BIT = 7;

	// Reset values
	localparam logic [7:0] RST_REG = 8'h00_00;

	// Source index, ordered by vector address
	localparam logic [3:0] SRC_EXT0 = 4'h0;
	localparam logic [3:0] SRC_TMR0 = 4'h1;
	localparam logic [3:0] SRC_EXT1 = 4'h2;
	localparam logic [3:0] SRC_TMR1 = 4'h3;
	localparam logic [3:0] SRC_UART = 4'h4;
	localparam logic [3:0] SRC_I2C  = 4'h5;
	localparam logic [3:0] SRC_CAP0 = 4'h6;
	localparam logic [3:0] SRC_ADC  = 4'h0_A;
	localparam logic [3:0] SRC_CMP0 = 4'h0_B;
	localparam logic [3:0] SRC_TOVF = 4'h0_E;

	// Vector base and spacing
	localparam logic [15:0] VEC_BASE = 16'h0003;
	localparam int          VEC_STEP_SHIFT = 3;

	// Special function register write/read access
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} fic_sfr_req_t;

	// Hardware event pulses from the sources
	typedef struct packed {
		logic [1:0] ext;
		logic [1:0] tmr;
		logic       uart_rx;
		logic       uart_tx;
		logic       i2c_status;
		logic       adc_done;
		logic [3:0] capture;
		logic [2:0] compare;
		logic       byte_ovf;
		logic       word_ovf;
	} fic_events_t;

	// Service state toward the core
	typedef enum logic [1:0] {
		FIC_IDLE,
		FIC_REQUEST
	} fic_state_t;

endpackage

// ---- hw/fic_arbiter.sv ----
// Picks the winning pending source by level and fixed in-level order
`timescale 1ns/10ps
module fic_arbiter #(
	parameter int N = 15
) (
	input  wire logic [N-1:0]   req,     // Enabled pending sources
	input  wire logic [2*N-1:0] lvl,     // Two-bit level per source
	output logic                found,   // A source wins
	output logic [3:0]          win,     // Winner index
	output logic [1:0]          win_lvl  // Winner level
);

	// Position 0 is polled first within a level
	localparam logic [3:0] POLL [0:14] = '{4'h0, 4'h5, 4'h0_A, 4'h1,
		4'h6, 4'h0_B, 4'h2, 4'h7, 4'h0_C, 4'h3, 4'h8, 4'h0_D, 4'h4,
		4'h9, 4'h0_E};

	// Highest level first, then polling order; strict > keeps earliest
	always_comb begin
		found   = 1'b0;
		win     = 4'h0;
		win_lvl = 2'b00;
		for (int i = 0; i < N; i++) begin
			if (req[POLL[i]] && (!found ||
			    lvl[2*POLL[i] +: 2] > win_lvl)) begin
				found   = 1'b1;
				win     = POLL[i];
				win_lvl = lvl[2*POLL[i] +: 2];
			end
		end
	end

endmodule

// ---- hw/fic_level_stack.sv ----
// Tracks which priority levels have a routine in service
`timescale 1ns/10ps
module fic_level_stack (
	input  wire logic       core_clk, // Core clock
	input  wire logic       rst_b,    // Async reset, active low
	input  wire logic       clk_en,   // Freezes state when low
	input  wire logic       push,     // Grant taken
	input  wire logic [1:0] push_lvl, // Level of granted routine
	input  wire logic       pop,      // Return from routine
	output logic [3:0]      active,   // One bit per level in service
	output logic [2:0]      cur_lvl   // Highest active level + 1, 0 none
);

	logic [3:0] active_r;
	logic [3:0] active_nxt;
	logic [3:0] top_mask;

	// Return always ends the highest active routine, so lower ones resume
	assign top_mask = active_r[3] ? 4'b1000 : active_r[2] ? 4'b0100 :
		active_r[1] ? 4'b0010 : active_r[0] ? 4'b0001 : 4'b0000;
	assign active_nxt = (active_r & ~(pop ? top_mask : 4'b0000)) |
		(push ? (4'b0001 << push_lvl) : 4'b0000);
	assign active  = active_r;
	assign cur_lvl = active_r[3] ? 3'd4 : active_r[2] ? 3'd3 :
		active_r[1] ? 3'd2 : active_r[0] ? 3'd1 : 3'd0;

	// Level bits
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			active_r <= 4'b0000;
		end else if (clk_en) begin
			active_r <= active_nxt;
		end
	end

endmodule

// ---- hw/fic_top.sv ----
// Fifteen-source four-level nested interrupt controller
// Functional notes
// - Fifteen sources, each any of four levels
// - Standard set: two pins, two timers, UART
// - Timer block gives eight requests, overflows ORed
// - Capture inputs set capture flags
// - Compare matches set compare flags
// - Byte and word overflow set overflow flags
// - Hardware never clears timer block flags
// - ADC request from conversion-done flag
// - Software may clear, not set, ADC flag
// - Other flags software set or clear freely
// - I2C request from serial-bus interrupt flag
// - Per-source enable: one permits, zero blocks
// - Global enable clear blocks every source
// - Two priority bits give levels zero to three
// - Grant only above every active routine level
// - Higher level pre-empts; lower resumes afterwards
// - Second enable register bit layout fixed
// - Standard low priority register bit layout fixed
// - Fixed in-level polling order among equals
// - Vectors 0003H to 0073H, step eight
`timescale 1ns/10ps
module fic_top (
	input  wire logic                core_clk,   // 20 MHz core clock
	input  wire logic                rst_b,      // Async reset, active low
	input  wire logic                clk_en,     // Freezes state when low
	input  wire fic_pkg::fic_sfr_req_t sfr,      // Register access
	input  wire fic_pkg::fic_events_t  evt,      // Source event pulses
	input  wire logic                ack,        // Core takes the vector
	input  wire logic                reti,       // Core returns from routine
	output logic [7:0]               rdata,      // Register read data
	output logic                     int_req,    // Request toward core
	output logic [15:0]              int_vector, // Vector of the request
	output logic [1:0]               int_level,  // Level of the request
	output logic [3:0]               in_service  // Levels in service
);

	localparam int N = fic_pkg::NUM_SRC;

	// Register state
	logic [7:0]   en_first_r;
	logic [7:0]   en_second_r;
	logic [7:0]   plow_std_r;
	logic [7:0]   phigh_std_r;
	logic [7:0]   plow_tmr_r;
	logic [7:0]   phigh_tmr_r;
	logic [N-1:0] flag_r;
	logic [N-1:0] flag_nxt;
	logic         byte_ovf_r;
	logic         word_ovf_r;
	logic         byte_ovf_nxt;
	logic         word_ovf_nxt;
	logic         uart_rx_r;
	logic         uart_tx_r;
	logic         uart_rx_nxt;
	logic         uart_tx_nxt;
	logic [7:0]   rdata_r;
	logic [7:0]   rdata_nxt;
	logic         int_req_r;
	logic [15:0]  int_vector_r;
	logic [1:0]   int_level_r;
	fic_pkg::fic_state_t state_r;
	fic_pkg::fic_state_t state_nxt;

	// Decoded writes
	wire wr_en1  = sfr.wr && sfr.addr == fic_pkg::ADDR_ENABLE_FIRST;
	wire wr_en2  = sfr.wr && sfr.addr == fic_pkg::ADDR_ENABLE_SECOND;
	wire wr_pls  = sfr.wr && sfr.addr == fic_pkg::ADDR_PRIO_LOW_STD;
	wire wr_phs  = sfr.wr && sfr.addr == fic_pkg::ADDR_PRIO_HIGH_STD;
	wire wr_plt  = sfr.wr && sfr.addr == fic_pkg::ADDR_PRIO_LOW_TMR;
	wire wr_pht  = sfr.wr && sfr.addr == fic_pkg::ADDR_PRIO_HIGH_TMR;
	wire wr_fstd = sfr.wr && sfr.addr == fic_pkg::ADDR_FLAGS_STD;
	wire wr_ftmr = sfr.wr && sfr.addr == fic_pkg::ADDR_FLAGS_TMR;
	wire wr_fovf = sfr.wr && sfr.addr == fic_pkg::ADDR_FLAGS_OVF;

	// Request vector built from flags
	logic [N-1:0] src_req;
	logic [N-1:0] src_en;
	logic [2*N-1:0] src_lvl;
	logic [N-1:0] eligible;

	// Standard flags by index; UART request is the OR of both flags
	assign src_req[0] = flag_r[0];
	assign src_req[1] = flag_r[1];
	assign src_req[2] = flag_r[2];
	assign src_req[3] = flag_r[3];
	assign src_req[4] = uart_rx_r | uart_tx_r;
	assign src_req[5] = flag_r[5];
	assign src_req[9:6]   = flag_r[9:6];
	assign src_req[10]    = flag_r[10];
	assign src_req[13:11] = flag_r[13:11];
	assign src_req[14]    = byte_ovf_r | word_ovf_r;

	// First enable: bits 0..6 are ext0,t0,ext1,t1,uart,i2c,adc
	// Second enable: captures 0..3, compares, overflow
	assign src_en[0] = en_first_r[0];
	assign src_en[1] = en_first_r[1];
	assign src_en[2] = en_first_r[2];
	assign src_en[3] = en_first_r[3];
	assign src_en[4] = en_first_r[4];
	assign src_en[5] = en_first_r[5];
	assign src_en[9:6]   = en_second_r[3:0];
	assign src_en[10]    = en_first_r[6];
	assign src_en[13:11] = en_second_r[6:4];
	assign src_en[14]    = en_second_r[7];

	// Per-source level from high and low priority bits
	function automatic logic [1:0] lvl_of(input logic hi, input logic lo);
		lvl_of = {hi, lo};
	endfunction

	// Standard low register: ext0,t0,ext1,t1,uart,i2c,adc at 0..6
	assign src_lvl[1:0]   = lvl_of(phigh_std_r[0], plow_std_r[0]);
	assign src_lvl[3:2]   = lvl_of(phigh_std_r[1], plow_std_r[1]);
	assign src_lvl[5:4]   = lvl_of(phigh_std_r[2], plow_std_r[2]);
	assign src_lvl[7:6]   = lvl_of(phigh_std_r[3], plow_std_r[3]);
	assign src_lvl[9:8]   = lvl_of(phigh_std_r[4], plow_std_r[4]);
	assign src_lvl[11:10] = lvl_of(phigh_std_r[5], plow_std_r[5]);
	assign src_lvl[13:12] = lvl_of(phigh_tmr_r[0], plow_tmr_r[0]);
	assign src_lvl[15:14] = lvl_of(phigh_tmr_r[1], plow_tmr_r[1]);
	assign src_lvl[17:16] = lvl_of(phigh_tmr_r[2], plow_tmr_r[2]);
	assign src_lvl[19:18] = lvl_of(phigh_tmr_r[3], plow_tmr_r[3]);
	assign src_lvl[21:20] = lvl_of(phigh_std_r[6], plow_std_r[6]);
	assign src_lvl[23:22] = lvl_of(phigh_tmr_r[4], plow_tmr_r[4]);
	assign src_lvl[25:24] = lvl_of(phigh_tmr_r[5], plow_tmr_r[5]);
	assign src_lvl[27:26] = lvl_of(phigh_tmr_r[6], plow_tmr_r[6]);
	assign src_lvl[29:28] = lvl_of(phigh_tmr_r[7], plow_tmr_r[7]);

	// Global enable gates every source regardless of its own bit
	assign eligible = src_req & src_en &
		{N{en_first_r[fic_pkg::EN_GLOBAL_BIT]}};

	// Arbitration
	logic       found;
	logic [3:0] win;
	logic [1:0] win_lvl;
	logic [3:0] active;
	logic [2:0] cur_lvl;

	fic_arbiter #(
		.N (N)
	) u_arb (
		.req     (eligible),
		.lvl     (src_lvl),
		.found   (found),
		.win     (win),
		.win_lvl (win_lvl)
	);

	// Granted only strictly above every routine in service
	wire grant_ok = found && ({1'b0, win_lvl} + 3'd1 > cur_lvl);
	// Only a request still shown counts, so a late ack is ignored
	wire take     = (state_r == fic_pkg::FIC_REQUEST) && int_req_r && ack;

	fic_level_stack u_stack (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.clk_en   (clk_en),
		.push     (take),
		.push_lvl (int_level_r),
		.pop      (reti),
		.active   (active),
		.cur_lvl  (cur_lvl)
	);

	// Vector address: base plus eight per source index
	wire [15:0] vec = fic_pkg::VEC_BASE +
		16'({12'h000, win} << fic_pkg::VEC_STEP_SHIFT);

	// Request is re-evaluated every cycle until the core takes it
	assign state_nxt = grant_ok ? fic_pkg::FIC_REQUEST : fic_pkg::FIC_IDLE;

	// Flag next state: hardware set wins over any software clear
	always_comb begin
		flag_nxt = flag_r;
		if (wr_fstd) begin
			flag_nxt[3:0] = sfr.wdata[3:0];
			flag_nxt[5]   = sfr.wdata[5];
			flag_nxt[10]  = flag_r[10] & sfr.wdata[6];
		end
		if (wr_ftmr) begin
			flag_nxt[9:6]   = sfr.wdata[3:0];
			flag_nxt[13:11] = sfr.wdata[6:4];
		end
		flag_nxt[0]     = flag_nxt[0] | evt.ext[0];
		flag_nxt[1]     = flag_nxt[1] | evt.tmr[0];
		flag_nxt[2]     = flag_nxt[2] | evt.ext[1];
		flag_nxt[3]     = flag_nxt[3] | evt.tmr[1];
		flag_nxt[5]     = flag_nxt[5] | evt.i2c_status;
		flag_nxt[9:6]   = flag_nxt[9:6] | evt.capture;
		flag_nxt[10]    = flag_nxt[10] | evt.adc_done;
		flag_nxt[13:11] = flag_nxt[13:11] | evt.compare;
		flag_nxt[4]     = 1'b0;
		flag_nxt[14]    = 1'b0;
	end

	// Flag index already equals the vector index of its source
	wire [N-1:0] flag_fix = flag_nxt;

	// UART and overflow flags, software writable both ways
	assign uart_rx_nxt  = (wr_fstd ? sfr.wdata[4] : uart_rx_r) | evt.uart_rx;
	assign uart_tx_nxt  = (wr_fovf ? sfr.wdata[2] : uart_tx_r) | evt.uart_tx;
	assign byte_ovf_nxt = (wr_fovf ? sfr.wdata[0] : byte_ovf_r) |
		evt.byte_ovf;
	assign word_ovf_nxt = (wr_fovf ? sfr.wdata[1] : word_ovf_r) |
		evt.word_ovf;

	// Read mux, unmapped addresses read zero
	always_comb begin
		unique case (sfr.addr)
			fic_pkg::ADDR_ENABLE_FIRST:  rdata_nxt = en_first_r;
			fic_pkg::ADDR_ENABLE_SECOND: rdata_nxt = en_second_r;
			fic_pkg::ADDR_PRIO_LOW_STD:  rdata_nxt = {1'b0, plow_std_r[6:0]};
			fic_pkg::ADDR_PRIO_HIGH_STD: rdata_nxt = {1'b0, phigh_std_r[6:0]};
			fic_pkg::ADDR_PRIO_LOW_TMR:  rdata_nxt = plow_tmr_r;
			fic_pkg::ADDR_PRIO_HIGH_TMR: rdata_nxt = phigh_tmr_r;
			fic_pkg::ADDR_FLAGS_STD:     rdata_nxt = {1'b0, flag_r[10],
				flag_r[5], uart_rx_r, flag_r[3], flag_r[2], flag_r[1],
				flag_r[0]};
			fic_pkg::ADDR_FLAGS_TMR:     rdata_nxt = {1'b0, flag_r[13:11],
				flag_r[9:6]};
			fic_pkg::ADDR_FLAGS_OVF:     rdata_nxt = {5'b0_0000, uart_tx_r,
				word_ovf_r, byte_ovf_r};
			default:                     rdata_nxt = fic_pkg::RST_REG;
		endcase
	end

	// Configuration registers
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			en_first_r  <= fic_pkg::RST_REG;
			en_second_r <= fic_pkg::RST_REG;
			plow_std_r  <= fic_pkg::RST_REG;
			phigh_std_r <= fic_pkg::RST_REG;
			plow_tmr_r  <= fic_pkg::RST_REG;
			phigh_tmr_r <= fic_pkg::RST_REG;
		end else if (clk_en) begin
			if (wr_en1) en_first_r <= sfr.wdata;
			if (wr_en2) en_second_r <= sfr.wdata;
			if (wr_pls) plow_std_r <= sfr.wdata;
			if (wr_phs) phigh_std_r <= sfr.wdata;
			if (wr_plt) plow_tmr_r <= sfr.wdata;
			if (wr_pht) phigh_tmr_r <= sfr.wdata;
		end
	end

	// Flags
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			flag_r     <= '0;
			uart_rx_r  <= 1'b0;
			uart_tx_r  <= 1'b0;
			byte_ovf_r <= 1'b0;
			word_ovf_r <= 1'b0;
		end else if (clk_en) begin
			flag_r     <= flag_fix;
			uart_rx_r  <= uart_rx_nxt;
			uart_tx_r  <= uart_tx_nxt;
			byte_ovf_r <= byte_ovf_nxt;
			word_ovf_r <= word_ovf_nxt;
		end
	end

	// Request toward the core, registered
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r      <= fic_pkg::FIC_IDLE;
			int_req_r    <= 1'b0;
			int_vector_r <= 16'h0000;
			int_level_r  <= 2'b00;
			rdata_r      <= fic_pkg::RST_REG;
		end else if (clk_en) begin
			state_r      <= state_nxt;
			int_req_r    <= grant_ok && !take;
			int_vector_r <= vec;
			int_level_r  <= win_lvl;
			rdata_r      <= rdata_nxt;
		end
	end

	assign rdata      = rdata_r;
	assign int_req    = int_req_r;
	assign int_vector = int_vector_r;
	assign int_level  = int_level_r;
	assign in_service = active;

endmodule

// ---- verification/fic_chk.sv ----
// Port-level assertion checker for the interrupt controller
`timescale 1ns/10ps
module fic_chk (
	input wire logic                  core_clk,   // Core clock
	input wire logic                  rst_b,      // Async reset, active low
	input wire logic                  clk_en,     // State enable
	input wire fic_pkg::fic_sfr_req_t sfr,        // Register access
	input wire fic_pkg::fic_events_t  evt,        // Source events
	input wire logic                  ack,        // Vector taken
	input wire logic                  reti,       // Routine return
	input wire logic [7:0]            rdata,      // Read data
	input wire logic                  int_req,    // Request to core
	input wire logic [15:0]           int_vector, // Presented vector
	input wire logic [1:0]            int_level,  // Presented level
	input wire logic [3:0]            in_service  // Active levels
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	// Active set with its highest level removed
	function automatic logic [3:0] pop_top(input logic [3:0] v);
		if (v[3])
			return {1'b0, v[2:0]};
		if (v[2])
			return {2'b00, v[1:0]};
		if (v[1])
			return {3'b000, v[0]};
		return 4'h0;
	endfunction

	// A grant counts only when the core takes it in an enabled cycle
	wire logic take = int_req && ack && clk_en;

	ack_sets_level_a: assert property (take |=> in_service[$past(int_level)])
		else $error("granted level not marked in service");
	grant_above_a: assert property (int_req |-> (in_service >> int_level) == 4'h0)
		else $error("request shown at or below an active level");
	vector_form_a: assert property (int_req |->
		int_vector[2:0] == 3'h3 && int_vector <= 16'h0073)
		else $error("vector outside the table");
	reti_pops_a: assert property (reti && clk_en && !take |=>
		in_service == pop_top($past(in_service)))
		else $error("return did not drop the top level");
	no_stray_a: assert property (!take |=>
		(in_service & ~$past(in_service)) == 4'h0)
		else $error("level entered service without a grant");
	req_holds_a: assert property (int_req && !take && !sfr.wr && !reti &&
		clk_en |=> int_req)
		else $error("pending request vanished untaken");
	enable2_read_a: assert property ((sfr.wr && clk_en &&
		sfr.addr == fic_pkg::ADDR_ENABLE_SECOND) ##1 (!sfr.wr &&
		sfr.addr == fic_pkg::ADDR_ENABLE_SECOND) |=>
		rdata == $past(sfr.wdata, 2))
		else $error("second enable register lost its value");
	prio_read_a: assert property ((sfr.wr && clk_en &&
		sfr.addr == fic_pkg::ADDR_PRIO_LOW_STD) ##1 (!sfr.wr &&
		sfr.addr == fic_pkg::ADDR_PRIO_LOW_STD) |=>
		rdata[6:0] == $past(sfr.wdata[6:0], 2))
		else $error("priority register lost its value");

	// Main scenarios reached
	cover property (in_service[3] && in_service[2]);
	cover property (take && int_level == 2'd3);
	cover property (reti && in_service == 4'h6);
endmodule

bind fic_top fic_chk fic_chk_inst (.core_clk(core_clk), .rst_b(rst_b),
	.clk_en(clk_en), .sfr(sfr), .evt(evt), .ack(ack), .reti(reti),
	.rdata(rdata), .int_req(int_req), .int_vector(int_vector),
	.int_level(int_level), .in_service(in_service));

// ---- verification/fic_core_model.sv ----
// Core sequencer model that takes vectors and returns from routines
`timescale 1ns/10ps
module fic_core_model (
	input  wire logic       core_clk, // Core clock
	input  wire logic       rst_b,    // Async reset, active low
	input  wire logic       int_req,  // Request from controller
	input  wire logic [1:0] dly,      // Stall cycles before taking
	input  wire logic       ret_go,   // Leave the current routine
	output logic            ack,      // Vector taken
	output logic            reti      // Routine return
);
	logic [1:0] wait_r;

	// Takes only a standing request, never twice running nor with a return
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ack <= 1'b0;
			reti <= 1'b0;
			wait_r <= 2'b00;
		end else begin
			ack <= 1'b0;
			reti <= ret_go;
			wait_r <= (int_req && !ack) ? wait_r + 2'b01 : 2'b00;
			if (int_req && !ack && !ret_go && wait_r >= dly)
				ack <= 1'b1;
		end
	end
endmodule

// ---- verification/fic_test.sv ----
// Self-checking bench for the four-level interrupt controller
`timescale 1ns/10ps
`define CHK(nm, e, g) begin \
	num_checks++; \
	if ((g) !== (e)) begin \
		miscompares++; \
		$display("BAD %s exp %h got %h", nm, e, g); \
	end \
end
module four_level_interrupt_controller_test;
	localparam logic [7:0] FS = fic_pkg::ADDR_FLAGS_STD;
	localparam logic [7:0] FT = fic_pkg::ADDR_FLAGS_TMR;
	localparam logic [7:0] FO = fic_pkg::ADDR_FLAGS_OVF;
	localparam logic [7:0] E1 = fic_pkg::ADDR_ENABLE_FIRST;
	localparam logic [7:0] PL = fic_pkg::ADDR_PRIO_LOW_STD;
	logic                  core_clk = 1'b0;
	logic                  rst_b = 1'b0;
	logic                  ret_go = 1'b0;
	logic [1:0]            dly = 2'b00;
	fic_pkg::fic_sfr_req_t sfr = '0;
	fic_pkg::fic_events_t  evt = '0;
	logic                  ack, reti, int_req;
	logic [1:0]            int_level;
	logic [7:0]            rdata, rv, wv;
	logic [15:0]           int_vector;
	logic [3:0]            in_service;
	logic [17:0]           exp_q[$], ex;
	int                    miscompares = 0, num_checks = 0;
	int                    acks = 0, cyc = 0;
	// Event bit, vector index and flag register of each source event
	int   ev_b[17] = '{15,13,16,14,12,11,10,5,6,7,8,9,2,3,4,1,0};
	int   ev_i[17] = '{0,1,2,3,4,4,5,6,7,8,9,10,11,12,13,14,14};
	logic [7:0] ev_a[17] = '{FS,FS,FS,FS,FS,FO,FS,FT,FT,FT,FT,FS,FT,FT,
		FT,FO,FO};
	logic [7:0] rg[4] = '{E1, PL, fic_pkg::ADDR_PRIO_HIGH_STD,
		fic_pkg::ADDR_ENABLE_SECOND};
	logic [7:0] rm[4] = '{8'hFF, 8'h7F, 8'h7F, 8'hFF};

	fic_top fic_top_inst (.core_clk(core_clk), .rst_b(rst_b), .clk_en(1'b1),
		.sfr(sfr), .evt(evt), .ack(ack), .reti(reti), .rdata(rdata),
		.int_req(int_req), .int_vector(int_vector), .int_level(int_level),
		.in_service(in_service));
	fic_core_model fic_core_model_inst (.core_clk(core_clk), .rst_b(rst_b),
		.int_req(int_req), .dly(dly), .ret_go(ret_go), .ack(ack),
		.reti(reti));

	initial forever #25 core_clk = ~core_clk;

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#2;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr.wr = 1'b1;
		sfr.addr = a;
		sfr.wdata = d;
		tick(1);
		sfr.wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		sfr.addr = a;
		tick(1);
		d = rdata;
	endtask
	task automatic fire(input logic [16:0] m);
		evt = fic_pkg::fic_events_t'(m);
		tick(1);
		evt = '0;
	endtask
	// Notes the grant, then waits a bounded time for the core to take it
	task automatic expect_grant(input int idx, input logic [1:0] lvl);
		int n;
		n = acks;
		exp_q.push_back({lvl, 16'h0003 + 16'(idx * 8)});
		dly = 2'($urandom % 4);
		for (int k = 0; k < 40 && acks == n; k++)
			@(posedge core_clk);
		#2;
		if (acks == n) begin
			miscompares++;
			$display("BAD grant exp %0d got none", idx);
		end
	endtask
	task automatic ret();
		ret_go = 1'b1;
		tick(1);
		ret_go = 1'b0;
		tick(1);
	endtask
	task automatic give_verdict();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Each taken vector is compared with the oldest note
	always @(posedge core_clk) begin
		if (rst_b && int_req && ack) begin
			acks <= acks + 1;
			if (exp_q.size() == 0) begin
				miscompares++;
				$display("BAD grant exp none got %h", int_vector);
			end else begin
				ex = exp_q.pop_front();
				`CHK("grant", ex, {int_level, int_vector})
			end
		end
	end

	// Cycle ceiling cuts a hung handshake short
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			give_verdict();
		end
	end

	initial begin
		void'($urandom(6088));
		tick(6);
		rst_b = 1'b1;
		// Reset values, then random write and readback
		foreach (rg[i]) begin
			rd(rg[i], rv);
			`CHK("reset", 8'h00, rv)
			repeat (3) begin
				wv = 8'($urandom);
				wr(rg[i], wv);
				rd(rg[i], rv);
				`CHK("readback", wv & rm[i], rv & rm[i])
			end
		end
		foreach (rg[i])
			wr(rg[i], (i == 0 || i == 3) ? 8'hFF : 8'h00);
		// Every source event once, all at level zero
		for (int i = 0; i < 17; i++) begin
			fire(17'h1 << ev_b[i]);
			expect_grant(ev_i[i], 2'd0);
			wr(ev_a[i], 8'h00);
			ret();
		end
		// Timer block flag recurs until software clears it
		fire(17'h1 << 6);
		expect_grant(7, 2'd0);
		ret();
		expect_grant(7, 2'd0);
		rd(FT, rv);
		`CHK("capture flag", 8'h02, rv)
		wr(FT, 8'h00);
		ret();
		// Software may clear but never set the converter flag
		wr(FS, 8'h40);
		tick(6);
		`CHK("adc set", 1'b0, int_req)
		fire(17'h1 << 9);
		rd(FS, rv);
		`CHK("adc flag", 8'h40, rv)
		expect_grant(10, 2'd0);
		wr(FS, 8'h00);
		rd(FS, rv);
		`CHK("adc clear", 8'h00, rv)
		ret();
		wr(FS, 8'h08);
		expect_grant(3, 2'd0);
		wr(FS, 8'h00);
		ret();
		// Both enables gate a pending source; software cancels it
		wr(E1, 8'h7F);
		fire(17'h1 << 15);
		tick(6);
		`CHK("global off", 1'b0, int_req)
		wr(E1, 8'h80);
		tick(6);
		`CHK("source off", 1'b0, int_req)
		wr(FS, 8'h00);
		wr(E1, 8'hFF);
		tick(6);
		`CHK("cancelled", 1'b0, int_req)
		fire(17'h1 << 15);
		expect_grant(0, 2'd0);
		wr(FS, 8'h00);
		ret();
		// Equal levels follow the fixed order, not vector order
		fire((17'h1 << 13) | (17'h1 << 9));
		expect_grant(10, 2'd0);
		wr(FS, 8'h02);
		ret();
		expect_grant(1, 2'd0);
		wr(FS, 8'h00);
		ret();
		// Nesting through levels one, two and three
		wr(PL, 8'h06);
		wr(rg[2], 8'h14);
		fire(17'h1 << 13);
		expect_grant(1, 2'd1);
		wr(FS, 8'h00);
		fire(17'h1 << 12);
		expect_grant(4, 2'd2);
		wr(FS, 8'h00);
		fire(17'h1 << 16);
		expect_grant(2, 2'd3);
		wr(FS, 8'h00);
		`CHK("nesting", 4'hE, in_service)
		fire(17'h1 << 15);
		tick(6);
		`CHK("lower waits", 1'b0, int_req)
		ret();
		`CHK("resume", 4'h6, in_service)
		ret();
		ret();
		expect_grant(0, 2'd0);
		wr(FS, 8'h00);
		ret();
		`CHK("idle", 4'h0, in_service)
		give_verdict();
	end
endmodule
